// ===== rtl/flash_clock_divider_and_params.sv
// Flash controller register front end: clock divider, parameter words, reserved regs
// Overview of operation
// - Loaded flag reads 0 after reset, 1 once divider register is written.
// - With lock clear, writes update the six-bit divide field.
// - Once lock is set, divide field frozen; only reset clears lock.
// - Divide field scales bus clock to about 1 MHz timing tick.
// - Parameter index 010..101 selects data words 0..3, high and low byte.
// - First reserved test register reads zero, ignores writes.
// - Second reserved test register reads zero, ignores writes.
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"
module flash_clock_divider_and_params (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             flashTick,
  output logic             commandCompleteFlag
);
  flash_ctl_pkg::apb_req_s   req;
  flash_ctl_pkg::apb_rsp_s   rsp_q;
  flash_ctl_pkg::apb_rsp_s   rsp_d;
  flash_ctl_pkg::cmd_state_e state_q;
  flash_ctl_pkg::cmd_state_e state_d;

  logic [`DIV_FIELD_W-1:0] divField_q;
  logic                    divLoaded_q;
  logic                    divLock_q;
  logic [`PIDX_W-1:0]      pidx_q;
  logic [15:0]             words_q [4];
  logic [15:0]             tickLeft_q;
  logic                    tickRaw;

  // Word index for a valid parameter index, used by read and write paths
  function automatic logic [1:0] word_of(input logic [`PIDX_W-1:0] idx);
    logic [`PIDX_W-1:0] diff;
    diff = idx - `PIDX_FIRST;
    return diff[1:0];
  endfunction

  // Exact match of the bus address against one register offset
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction

  assign req = '{sel: psel, en: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // Access phase decode; answer one cycle after penable rises (one wait state)
  wire access   = req.sel && req.en && !rsp_q.ready;
  wire doWrite  = access && req.write;
  wire hitDiv   = addr_hit(req.addr, `OFF_CLKDIV);
  wire hitCmd   = addr_hit(req.addr, `OFF_CMDSTAT);
  wire hitPidx  = addr_hit(req.addr, `OFF_PIDX);
  wire hitWord  = addr_hit(req.addr, `OFF_PWORD);
  wire hitTick  = addr_hit(req.addr, `OFF_TICKCNT);
  wire hitRsv   = addr_hit(req.addr, `OFF_RSV1) || addr_hit(req.addr, `OFF_RSV2) ||
                  addr_hit(req.addr, `OFF_RSV3);
  wire mapped   = hitDiv || hitCmd || hitPidx || hitWord || hitTick || hitRsv;
  wire pidxOk   = (pidx_q >= `PIDX_FIRST) && (pidx_q <= `PIDX_LAST);
  wire busy     = (state_q == flash_ctl_pkg::CMD_BUSY);
  wire divWrite = doWrite && hitDiv;
  wire divOpen  = !divLock_q;
  wire launch   = doWrite && hitCmd && pwdata[`CMD_START_BIT] && !busy;
  wire [1:0] wIdx = word_of(pidx_q);

  // Write strobes and countdown enable shared by the register processes
  wire pidxWrite  = doWrite && hitPidx;
  wire wordWrite  = doWrite && hitWord && pidxOk && !busy;
  wire divFieldWr = divWrite && divOpen;
  wire tickDec    = busy && tickRaw && (tickLeft_q != 16'h0000);

  // Read mux; reserved test registers and unmapped holes read zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitDiv) begin
      rdMux[`DIV_LOADED_BIT]   = divLoaded_q;
      rdMux[`DIV_LOCK_BIT]     = divLock_q;
      rdMux[`DIV_FIELD_W-1:0]  = divField_q;
    end else if (hitCmd) begin
      rdMux[`CMD_DONE_BIT]     = !busy;
    end else if (hitPidx) begin
      rdMux[`PIDX_W-1:0]       = pidx_q;
    end else if (hitWord && pidxOk) begin
      rdMux[15:0]              = words_q[wIdx];
    end else if (hitTick) begin
      rdMux[15:0]              = tickLeft_q;
    end
  end

  // Slave answers; unmapped address gets an error, reserved ones do not
  always_comb begin
    rsp_d = '{ready: access, rdata: 32'h0000_0000, slverr: 1'b0};
    if (access) begin
      rsp_d.rdata  = req.write ? 32'h0000_0000 : rdMux;
      rsp_d.slverr = !mapped;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign pready  = rsp_q.ready;
  assign prdata  = rsp_q.rdata;
  assign pslverr = rsp_q.slverr;

  // Divide field: only an open lock lets a write through
  // A write while busy is the software's fault; accepted to keep logic small
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divField_q <= `DIV_RESET;
    end else if (divFieldWr) begin
      divField_q <= pwdata[`DIV_FIELD_W-1:0];
    end
  end

  // Loaded flag: any divider write sets it, only reset clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divLoaded_q <= 1'b0;
    end else if (divWrite) begin
      divLoaded_q <= 1'b1;
    end
  end

  // Lock: write-one sticky, so a later zero cannot reopen the field
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divLock_q <= 1'b0;
    end else if (divWrite && pwdata[`DIV_LOCK_BIT]) begin
      divLock_q <= 1'b1;
    end
  end

  // Parameter index register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pidx_q <= `PIDX_RESET;
    end else if (pidxWrite) begin
      pidx_q <= pwdata[`PIDX_W-1:0];
    end
  end

  // Parameter words; writes with an out-of-range index are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        words_q[i] <= 16'h0000;
      end
    end else if (wordWrite) begin
      words_q[wIdx] <= pwdata[15:0];
    end
  end

  // Tick generator derives ~1 MHz timing from the divide field
  flash_tick_gen u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .divValue (divField_q),
    .tick     (tickRaw)
  );

  // Command sequencer: a timed operation counts flash ticks down
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      flash_ctl_pkg::CMD_IDLE: if (launch) state_d = flash_ctl_pkg::CMD_BUSY;
      flash_ctl_pkg::CMD_BUSY: if (tickRaw && tickLeft_q == 16'h0001) begin
        state_d = flash_ctl_pkg::CMD_IDLE;
      end
      default: state_d = flash_ctl_pkg::CMD_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= flash_ctl_pkg::CMD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Remaining ticks of the running operation, ~1 us each
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tickLeft_q <= 16'h0000;
    end else if (launch) begin
      tickLeft_q <= 16'(`CMD_LEN_TICKS);
    end else if (tickDec) begin
      tickLeft_q <= tickLeft_q - 16'h0001;
    end
  end

  // Tick output, one cycle behind the generator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flashTick <= 1'b0;
    end else begin
      flashTick <= tickRaw;
    end
  end

  // Completion flag from the next state, so it drops on the launch edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      commandCompleteFlag <= 1'b1;
    end else begin
      commandCompleteFlag <= (state_d == flash_ctl_pkg::CMD_IDLE);
    end
  end
endmodule

// ===== rtl/flash_ctl_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

`define OFF_CLKDIV     12'h000
`define OFF_CMDSTAT    12'h004
`define OFF_PIDX       12'h008
`define IDX_RSV1       12'h00C
`define IDX_RSV2       12'h00D
`define IDX_RSV3       12'h00E
`define OFF_RSV1       12'h030
`define OFF_RSV2       12'h034
`define OFF_RSV3       12'h038
`define OFF_PWORD      12'h040
`define OFF_TICKCNT    12'h044

`define DIV_LOADED_BIT 7
`define DIV_LOCK_BIT   6
`define DIV_FIELD_W    6
`define DIV_RESET      6'h00
`define PIDX_W         3
`define PIDX_RESET     3'h0
`define PIDX_FIRST     3'h2
`define PIDX_LAST      3'h5
`define CMD_START_BIT  0
`define CMD_DONE_BIT   0
`define CMD_LEN_NS     1000
`define CLK_PERIOD_NS  10
`define CMD_LEN_CYC    (((`CMD_LEN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define TICK_NS        1000
`define CMD_LEN_TICKS  ((`CMD_LEN_NS) / (`TICK_NS))

`endif

// ===== rtl/flash_ctl_pkg.sv
// Types shared by the flash register front end
package flash_ctl_pkg;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
    logic        slverr;
  } apb_rsp_s;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_BUSY = 2'b10
  } cmd_state_e;

endpackage

// ===== rtl/flash_tick_gen.sv
// Divider that turns the bus clock into a ~1 MHz timing tick
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"
module flash_tick_gen (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [`DIV_FIELD_W-1:0]   divValue,
  output logic                           tick
);
  logic [`DIV_FIELD_W-1:0] cnt_q;
  logic [`DIV_FIELD_W-1:0] cnt_d;
  logic                    wrap;

  // Period is divValue+1 bus cycles; a tick pulses at each wrap
  assign wrap  = (cnt_q >= divValue);
  assign cnt_d = wrap ? '0 : cnt_q + `DIV_FIELD_W'(1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= wrap;
    end
  end
endmodule

// ===== test/flash_regs_checker.sv
// Concurrent checks on the flash register front end ports
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"
module flash_regs_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        flashTick
);
  logic       loaded_q, lock_q, seen_q, chg_q;
  logic [5:0] div_q, gap_q;
  logic [2:0] idx_q;
  // Completed writes only; the bus takes them at the pready edge
  wire        wrDone = psel && penable && pready && pwrite;
  wire        divWr  = wrDone && paddr == `OFF_CLKDIV;
  // Shadow of what software wrote, and tick spacing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {loaded_q, lock_q, div_q, idx_q, seen_q, chg_q, gap_q} <= '0;
    end else begin
      if (divWr) {loaded_q, lock_q} <= {1'b1, lock_q | pwdata[6]};
      if (divWr && !lock_q) div_q <= pwdata[5:0];
      if (wrDone && paddr == `OFF_PIDX) idx_q <= pwdata[2:0];
      gap_q <= flashTick ? 6'h00 : gap_q + 6'h01;
      seen_q <= seen_q | flashTick;
      // An interval cut by a divider write is not judged
      chg_q <= divWr | (chg_q & !flashTick);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [11:0] a);
    psel && penable && !pready && !pwrite && paddr == a;
  endsequence
  sequence s_zero;
    pready && prdata == 32'h0000_0000 && !pslverr;
  endsequence
  property p_rsv1; s_rd(`OFF_RSV1) |=> s_zero; endproperty
  property p_rsv2; s_rd(`OFF_RSV2) |=> s_zero; endproperty
  property p_rsv3; s_rd(`OFF_RSV3) |=> s_zero; endproperty
  property p_loaded; s_rd(`OFF_CLKDIV) |=> pready && prdata[7] == loaded_q; endproperty
  property p_lock; s_rd(`OFF_CLKDIV) |=> prdata[6] == lock_q; endproperty
  property p_div; s_rd(`OFF_CLKDIV) |=> prdata[5:0] == div_q; endproperty
  property p_tick; flashTick && seen_q && !chg_q |-> gap_q == div_q; endproperty
  property p_word;
    s_rd(`OFF_PWORD) ##0 (idx_q < `PIDX_FIRST || idx_q > `PIDX_LAST) |=> s_zero;
  endproperty
  a_rsv1: assert property (p_rsv1) else $error("reserved one not zero");
  a_rsv2: assert property (p_rsv2) else $error("reserved two not zero");
  a_rsv3: assert property (p_rsv3) else $error("reserved three not zero");
  a_loaded: assert property (p_loaded) else $error("loaded flag wrong");
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  a_div: assert property (p_div) else $error("divide field wrong");
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  a_word: assert property (p_word) else $error("word outside index not zero");
endmodule
bind flash_clock_divider_and_params flash_regs_checker u_chk (.core_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .flashTick);

// ===== test/tb_top.sv
// Self-checking testbench for the flash register front end
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"
module tb_top;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, flashTick, errQ;
  logic        commandCompleteFlag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdQ;
  int          errTotal, nChecks;
  flash_clock_divider_and_params dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .flashTick, .commandCompleteFlag);
  // Free-running bus clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that used up its bound is a mismatch and ends the run
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      errTotal++;
      tally_and_finish();
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {rdQ, errQ} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      errTotal++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdQ, exp);
  endtask
  // Edges between two ticks, after skipping to the first tick
  task automatic period(input logic [31:0] exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (flashTick !== 1'b1 && n < 100);
      give_up(n, 100);
    end
    chk(32'(n), exp);
  endtask
  task automatic t_divider();
    rd(`OFF_CLKDIV, 32'h0000_0000);
    xfer(1'b1, `OFF_CLKDIV, 32'h0000_0018);
    rd(`OFF_CLKDIV, 32'h0000_0098);
    period(32'h0000_0019);
    xfer(1'b1, `OFF_CLKDIV, 32'h0000_0047);
    rd(`OFF_CLKDIV, 32'h0000_00C7);
    xfer(1'b1, `OFF_CLKDIV, 32'h0000_0002);
    rd(`OFF_CLKDIV, 32'h0000_00C7);
    period(32'h0000_0008);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(`OFF_CLKDIV, 32'h0000_0000);
    xfer(1'b1, `OFF_CLKDIV, 32'h0000_0003);
    rd(`OFF_CLKDIV, 32'h0000_0083);
  endtask
  // Out-of-range index must neither read nor disturb stored words
  task automatic t_words();
    for (int i = 2; i < 6; i++) begin
      xfer(1'b1, `OFF_PIDX, 32'(i));
      xfer(1'b1, `OFF_PWORD, 32'h0000_A500 + 32'(i));
    end
    xfer(1'b1, `OFF_PIDX, 32'h0000_0000);
    xfer(1'b1, `OFF_PWORD, 32'h0000_FFFF);
    rd(`OFF_PWORD, 32'h0000_0000);
    for (int i = 5; i > 1; i--) begin
      xfer(1'b1, `OFF_PIDX, 32'(i));
      rd(`OFF_PWORD, 32'h0000_A500 + 32'(i));
    end
  endtask
  task automatic t_reserved();
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `OFF_RSV1 + 12'(4 * i), 32'hFFFF_FFFF);
      rd(`OFF_RSV1 + 12'(4 * i), 32'h0000_0000);
      chk({31'h0, errQ}, 32'h0000_0000);
    end
    xfer(1'b0, 12'h0FC, 32'h0000_0000);
    chk({31'h0, errQ}, 32'h0000_0001);
  endtask
  // Timed command launched just after a tick: busy window, refused word write
  task automatic t_command();
    int n;
    chk({31'h0, commandCompleteFlag}, 32'h0000_0001);
    xfer(1'b1, `OFF_CLKDIV, 32'h0000_0018);
    xfer(1'b1, `OFF_PIDX, 32'h0000_0002);
    rd(`OFF_CMDSTAT, 32'h0000_0001);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (flashTick !== 1'b1 && n < 100);
    give_up(n, 100);
    xfer(1'b1, `OFF_CMDSTAT, 32'h0000_0001);
    chk({31'h0, commandCompleteFlag}, 32'h0000_0000);
    xfer(1'b1, `OFF_PWORD, 32'h0000_1234);
    rd(`OFF_CMDSTAT, 32'h0000_0000);
    rd(`OFF_TICKCNT, 32'h0000_0001);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (commandCompleteFlag !== 1'b1 && n < 100);
    give_up(n, 100);
    chk({31'h0, flashTick}, 32'h0000_0001);
    rd(`OFF_TICKCNT, 32'h0000_0000);
    rd(`OFF_CMDSTAT, 32'h0000_0001);
    rd(`OFF_PWORD, 32'h0000_A502);
  endtask
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0000_0000};
    errTotal = 0;
    nChecks = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_divider();
    t_words();
    t_reserved();
    t_command();
    tally_and_finish();
  end
endmodule
